// *** dcru_top.sv ***
// dcru_top: dual clock and reset unit with apb register access
// assumes core_clk_i is the running main clock; halt requests come from same-clock logic
//
// Functional notes
// [RL1] main halt request stops main oscillator and holds 14-bit timer at 3fff
// [RL2] main halt release restarts oscillator; timer counts to zero, then main good
// [RL3] main good comes 32768 main clock cycles after restart; the timer gives 32766 (16383 steps of two cycles from 3fff)
// [RL4] slow halt request disables slow oscillator and holds 6-bit timer at 3f
// [RL5] slow halt release starts oscillator; timer counts to zero, then slow good
// [RL6] slow clock from fixed divide-by-2 and 8-bit divisor, divisors 2 to 512
// [RL7] prescaled source divides main clock by (slow divisor field + 1) * 2
// [RL8] slow clock divisor register resets to ff
// [RL9] software keeps the slow clock at or below 100 kHz
// [RL10] after reset the prescaled main clock is the slow clock
// [RL11] oscillator source used only while that oscillator is seen toggling
// [RL12] control bit 0 selects oscillator when 1, prescaler when 0, resets 0
// [RL13] control byte: bit 0 select, bit 1 power-up flag, bits 7..2 reserved
// [RL14] power-up presets 14-bit timer; internal reset released at zero unless pin low
// [RL15] hardware sets power-up flag; software writing 0 clears it, writing 1 ignored
// [RL16] low external reset pin holds internal reset until pin goes high
// [RL17] aux divisors reset 00; each nibble divides main clock by value plus 1
// [RL18] each stable indication drops at once on halt request, until timer reaches zero
// [RL19] external-pin reset leaves the power-up flag unchanged
`timescale 1ns/1ps
module dcru_top #(
   parameter logic [13:0] MAIN_PRESET = dcru_pkg::MAIN_TMR_PRESET
) (
   // clock and power-on reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [dcru_pkg::ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // power management requests
   input wire logic stop_main_osc_i,
   input wire logic stop_slow_osc_i,
   // pins
   input wire logic ext_rst_n_i,
   input wire logic slow_osc_i,
   // oscillator enables and stable indications
   output logic main_osc_en_o,
   output logic slow_osc_en_o,
   output logic main_good_o,
   output logic slow_good_o,
   // derived clocks and reset
   output logic slow_clk_o,
   output logic aux_first_en_o,
   output logic aux_second_en_o,
   output logic sys_rst_n_o,
   // interrupt
   output logic irq_o
);

   // pin synchronisers
   logic ext_rst_meta_ff;
   logic ext_rst_sync_ff;
   logic slow_meta_ff;
   logic slow_sync_ff;
   logic slow_prev_ff;

   // registers
   logic slow_sel_ff;
   logic power_up_ff;
   logic [7:0] slow_div_ff;
   logic [7:0] aux_div_ff;
   logic [dcru_pkg::IRQ_W-1:0] irq_stat_ff;
   logic [dcru_pkg::IRQ_W-1:0] irq_mask_ff;
   logic irq_ff;

   // apb answer
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;

   // oscillator control and status
   logic main_osc_en_ff;
   logic slow_osc_en_ff;
   logic main_step_ff;
   logic main_good_prev_ff;
   logic slow_good_prev_ff;
   logic [dcru_pkg::WDOG_W-1:0] wdog_ff;
   logic slow_alive_ff;
   logic slow_clk_ff;
   logic prescale_half_ff;
   logic sys_rst_n_ff;

   // submodule outputs and the slow source choice
   logic main_good;
   logic slow_good;
   logic por_done;
   logic prescale_tick;
   logic aux_first_tick;
   logic aux_second_tick;
   logic slow_from_osc;

   // soft reset: power-on or synchronised external pin
   wire soft_rstn = rstn_i & ext_rst_sync_ff;

   // pin inputs pass two flip-flops before any logic reads them
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         ext_rst_meta_ff <= 1'b0;
         ext_rst_sync_ff <= 1'b0;
         slow_meta_ff <= 1'b0;
         slow_sync_ff <= 1'b0;
         slow_prev_ff <= 1'b0;
      end else begin
         ext_rst_meta_ff <= ext_rst_n_i;
         ext_rst_sync_ff <= ext_rst_meta_ff;
         slow_meta_ff <= slow_osc_i;
         slow_sync_ff <= slow_meta_ff;
         slow_prev_ff <= slow_sync_ff;
      end
   end

   // rising edge of the slow oscillator, seen only after the second stage
   wire slow_rise = slow_sync_ff & ~slow_prev_ff;

   // apb decode
   wire apb_setup = psel_i & ~penable_i;
   wire apb_done = psel_i & penable_i & pready_ff;
   wire apb_wr = apb_done & pwrite_i;
   wire hit_ctrl = (paddr_i == dcru_pkg::OFS_CLOCK_RESET_CONTROL);
   wire hit_sdiv = (paddr_i == dcru_pkg::OFS_SLOW_CLOCK_DIVISOR);
   wire hit_adiv = (paddr_i == dcru_pkg::OFS_AUX_SLOW_CLOCK_DIVISORS);
   wire hit_istat = (paddr_i == dcru_pkg::OFS_IRQ_STATUS);
   wire hit_imask = (paddr_i == dcru_pkg::OFS_IRQ_MASK);
   wire hit_ustat = (paddr_i == dcru_pkg::OFS_UNIT_STATUS);
   wire hit_any = hit_ctrl | hit_sdiv | hit_adiv | hit_istat | hit_imask | hit_ustat;

   // read data multiplexer; reserved and unmapped bits read as zero
   wire [7:0] ctrl_rd = {6'h00, power_up_ff, slow_sel_ff}; // [RL13]
   wire [7:0] ustat_rd = {3'h0, sys_rst_n_ff, slow_from_osc, slow_alive_ff,
                          slow_good, main_good};
   wire [31:0] rd_mux = hit_ctrl ? {24'h000000, ctrl_rd} :
                        hit_sdiv ? {24'h000000, slow_div_ff} :
                        hit_adiv ? {24'h000000, aux_div_ff} :
                        hit_istat ? {29'h00000000, irq_stat_ff} :
                        hit_imask ? {29'h00000000, irq_mask_ff} :
                        hit_ustat ? {24'h000000, ustat_rd} : 32'h00000000;

   // apb answer: pready rises in the second access cycle, data held with it
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h00000000;
      end else begin
         pready_ff <= psel_i & penable_i & ~pready_ff;
         pslverr_ff <= psel_i & penable_i & ~pready_ff & ~hit_any;
         if (apb_setup && !pwrite_i) begin
            prdata_ff <= rd_mux;
         end
      end
   end

   // slow select and divisors; the external pin resets them too
   always_ff @(posedge core_clk_i) begin
      if (!soft_rstn) begin
         slow_sel_ff <= dcru_pkg::CTRL_SLOW_SEL_RST; // [RL10] [RL12]
         slow_div_ff <= dcru_pkg::SLOW_DIV_RST; // [RL8]
         aux_div_ff <= dcru_pkg::AUX_DIV_RST; // [RL17]
         irq_mask_ff <= '0;
      end else if (apb_wr) begin
         if (hit_ctrl) begin
            slow_sel_ff <= pwdata_i[dcru_pkg::CTRL_SLOW_SEL_BIT]; // [RL12]
         end
         if (hit_sdiv) begin
            slow_div_ff <= pwdata_i[7:0];
         end
         if (hit_adiv) begin
            aux_div_ff <= pwdata_i[7:0];
         end
         if (hit_imask) begin
            irq_mask_ff <= pwdata_i[dcru_pkg::IRQ_W-1:0];
         end
      end
   end

   // power-up flag: only power-on reset sets it, so a pin reset keeps it
   wire pu_clear = apb_wr & hit_ctrl & ~pwdata_i[dcru_pkg::CTRL_POWER_UP_BIT];
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         power_up_ff <= dcru_pkg::CTRL_POWER_UP_RST; // [RL15] [RL19]
      end else if (pu_clear) begin
         power_up_ff <= 1'b0; // writing 1 never sets it [RL15]
      end
   end

   // oscillator enables follow the halt requests one cycle later
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         main_osc_en_ff <= 1'b1;
         slow_osc_en_ff <= 1'b1;
      end else begin
         main_osc_en_ff <= ~stop_main_osc_i; // [RL1] [RL2]
         slow_osc_en_ff <= ~stop_slow_osc_i; // [RL4] [RL5]
      end
   end

   // half-rate step: 16383 timer steps cover 32766 main cycles
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i || stop_main_osc_i) begin
         main_step_ff <= 1'b0;
      end else begin
         main_step_ff <= ~main_step_ff; // [RL3]
      end
   end

   // main start-up timer: preset while halted, done drops on the request
   dcru_stable_timer #(
      .W(dcru_pkg::MAIN_TMR_W),
      .PRESET(MAIN_PRESET)
   ) u_main_tmr (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .hold_i(stop_main_osc_i), // [RL1] [RL18]
      .step_i(main_step_ff), // [RL2] [RL3]
      .done_o(main_good)
   );

   // slow start-up timer steps on each oscillator rising edge
   dcru_stable_timer #(
      .W(dcru_pkg::SLOW_TMR_W),
      .PRESET(dcru_pkg::SLOW_TMR_PRESET)
   ) u_slow_tmr (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .hold_i(stop_slow_osc_i), // [RL4] [RL18]
      .step_i(slow_rise), // [RL5]
      .done_o(slow_good)
   );

   // power-on timer: preset by power-on reset, counts as soon as clock runs
   dcru_stable_timer #(
      .W(dcru_pkg::MAIN_TMR_W),
      .PRESET(MAIN_PRESET)
   ) u_por_tmr (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .hold_i(1'b0),
      .step_i(main_step_ff), // [RL14]
      .done_o(por_done)
   );

   // internal reset released only when both the timer and the pin allow it
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         sys_rst_n_ff <= 1'b0;
      end else begin
         sys_rst_n_ff <= por_done & ext_rst_sync_ff; // [RL14] [RL16]
      end
   end

   // toggle watchdog: a stuck oscillator still counted as stable must not feed the slow clock
   wire wdog_expired = (wdog_ff == dcru_pkg::WDOG_W'(dcru_pkg::SLOW_TOGGLE_TIMEOUT_CYC));
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i || slow_rise) begin
         wdog_ff <= '0;
      end else if (!wdog_expired) begin
         wdog_ff <= wdog_ff + 1'b1;
      end
   end

   // alive means stable and still toggling
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         slow_alive_ff <= 1'b0;
      end else begin
         slow_alive_ff <= slow_good & ~wdog_expired & slow_osc_en_ff; // [RL11]
      end
   end

   // source choice: oscillator only when selected and alive, prescaler otherwise
   assign slow_from_osc = slow_sel_ff & slow_alive_ff; // [RL11] [RL12]

   // prescaler runs only while it is the slow source; it stops otherwise to save power
   dcru_clk_div #(
      .W(8)
   ) u_slow_div (
      .core_clk_i(core_clk_i),
      .rstn_i(soft_rstn),
      .en_i(~slow_from_osc), // [RL11]
      .div_i(slow_div_ff), // [RL6] [RL7]
      .tick_o(prescale_tick)
   );

   // fixed divide-by-2 stage: period (div + 1) * 2, range 2 to 512
   always_ff @(posedge core_clk_i) begin
      if (!soft_rstn) begin
         prescale_half_ff <= 1'b0;
      end else if (prescale_tick) begin
         prescale_half_ff <= ~prescale_half_ff; // [RL6] [RL7]
      end
   end

   // slow clock output; the 100 kHz ceiling is left to software
   always_ff @(posedge core_clk_i) begin
      if (!soft_rstn) begin
         slow_clk_ff <= 1'b0;
      end else begin
         slow_clk_ff <= slow_from_osc ? slow_sync_ff : prescale_half_ff; // [RL10] [RL9]
      end
   end

   // auxiliary slow clocks: one-cycle enables every (nibble + 1) main cycles
   dcru_clk_div #(
      .W(dcru_pkg::AUX_W)
   ) u_aux_first (
      .core_clk_i(core_clk_i),
      .rstn_i(soft_rstn),
      .en_i(1'b1),
      .div_i(aux_div_ff[dcru_pkg::AUX_FIRST_LSB +: dcru_pkg::AUX_W]), // [RL17]
      .tick_o(aux_first_tick)
   );

   dcru_clk_div #(
      .W(dcru_pkg::AUX_W)
   ) u_aux_second (
      .core_clk_i(core_clk_i),
      .rstn_i(soft_rstn),
      .en_i(1'b1),
      .div_i(aux_div_ff[dcru_pkg::AUX_SECOND_LSB +: dcru_pkg::AUX_W]), // [RL17]
      .tick_o(aux_second_tick)
   );

   // interrupt events: stable rises and a refused oscillator selection
   wire sel_refused = apb_wr & hit_ctrl & pwdata_i[dcru_pkg::CTRL_SLOW_SEL_BIT] &
                      ~slow_alive_ff;
   wire [dcru_pkg::IRQ_W-1:0] irq_evt = {sel_refused,
                                         slow_good & ~slow_good_prev_ff,
                                         main_good & ~main_good_prev_ff};
   wire [dcru_pkg::IRQ_W-1:0] irq_w1c = (apb_wr & hit_istat) ?
                                        pwdata_i[dcru_pkg::IRQ_W-1:0] : '0;

   // sticky status, write one to clear; an event in the clear cycle wins
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         main_good_prev_ff <= 1'b0;
         slow_good_prev_ff <= 1'b0;
         irq_stat_ff <= '0;
         irq_ff <= 1'b0;
      end else begin
         main_good_prev_ff <= main_good;
         slow_good_prev_ff <= slow_good;
         irq_stat_ff <= (irq_stat_ff & ~irq_w1c) | irq_evt;
         irq_ff <= |(((irq_stat_ff & ~irq_w1c) | irq_evt) & irq_mask_ff);
      end
   end

   // outputs
   assign prdata_o = prdata_ff;
   assign pready_o = pready_ff;
   assign pslverr_o = pslverr_ff;
   assign main_osc_en_o = main_osc_en_ff;
   assign slow_osc_en_o = slow_osc_en_ff;
   assign main_good_o = main_good;
   assign slow_good_o = slow_good;
   assign slow_clk_o = slow_clk_ff;
   assign aux_first_en_o = aux_first_tick;
   assign aux_second_en_o = aux_second_tick;
   assign sys_rst_n_o = sys_rst_n_ff;
   assign irq_o = irq_ff;

endmodule : dcru_top

// *** dcru_pkg.sv ***
// dcru_pkg: constants of the dual clock and reset unit (register map, fields, timing)
// assumes a single 10 MHz core clock; used by dcru_top only
package dcru_pkg;

   // core clock
   localparam int CORE_CLK_HZ = 10_000_000;

   // apb register map, byte addresses of aligned 32-bit words
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_CLOCK_RESET_CONTROL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_SLOW_CLOCK_DIVISOR = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_AUX_SLOW_CLOCK_DIVISORS = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_UNIT_STATUS = 8'h14;

   // clock_reset_control fields
   localparam int CTRL_SLOW_SEL_BIT = 0;
   localparam int CTRL_POWER_UP_BIT = 1;
   localparam logic CTRL_SLOW_SEL_RST = 1'b0;
   localparam logic CTRL_POWER_UP_RST = 1'b1;

   // divisor registers
   localparam logic [7:0] SLOW_DIV_RST = 8'hff;
   localparam logic [7:0] AUX_DIV_RST = 8'h00;
   localparam int AUX_FIRST_LSB = 0;
   localparam int AUX_SECOND_LSB = 4;
   localparam int AUX_W = 4;

   // interrupt event bits
   localparam int IRQ_W = 3;
   localparam int IRQ_MAIN_GOOD = 0;
   localparam int IRQ_SLOW_GOOD = 1;
   localparam int IRQ_SEL_REFUSED = 2;

   // unit status bits
   localparam int ST_MAIN_GOOD = 0;
   localparam int ST_SLOW_GOOD = 1;
   localparam int ST_SLOW_ALIVE = 2;
   localparam int ST_SLOW_FROM_OSC = 3;
   localparam int ST_SYS_RUN = 4;

   // start-up timers
   localparam int MAIN_TMR_W = 14;
   localparam logic [13:0] MAIN_TMR_PRESET = 14'h3fff;
   localparam int SLOW_TMR_W = 6;
   localparam logic [5:0] SLOW_TMR_PRESET = 6'h3f;
   // main timer steps once per two core cycles: 16383 steps span 32766 cycles
   localparam int MAIN_TMR_STEP_DIV = 2;

   // slow oscillator toggle watchdog: two periods of 32.768 kHz, longest time rounds down
   localparam int SLOW_TOGGLE_TIMEOUT_NS = 61035;
   localparam int SLOW_TOGGLE_TIMEOUT_CYC = (SLOW_TOGGLE_TIMEOUT_NS / 100 > 1) ?
                                            SLOW_TOGGLE_TIMEOUT_NS / 100 : 1;
   localparam int WDOG_W = 10;

endpackage : dcru_pkg

// *** dcru_clk_div.sv ***
// dcru_clk_div: programmable divider giving a one-cycle enable every (div_i + 1) cycles
// assumes div_i is stable from the same clock; synchronous active-low reset
`timescale 1ns/1ps
module dcru_clk_div #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // control
   input wire logic en_i,
   input wire logic [W-1:0] div_i,
   // enable pulse
   output logic tick_o
);

   logic [W-1:0] cnt_ff;
   logic tick_ff;
   wire wrap = (cnt_ff >= div_i);

   // counter restarts when disabled so a new divisor takes effect cleanly
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i || !en_i) begin
         cnt_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         cnt_ff <= wrap ? '0 : cnt_ff + 1'b1;
         tick_ff <= wrap;
      end
   end

   assign tick_o = tick_ff;

endmodule : dcru_clk_div

// *** dcru_stable_timer.sv ***
// dcru_stable_timer: preset down-counter that stops at zero and flags done
// assumes hold_i and step_i come from the same clock; synchronous active-low reset
`timescale 1ns/1ps
module dcru_stable_timer #(
   parameter int W = 14,
   parameter logic [W-1:0] PRESET = '1
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // control
   input wire logic hold_i,
   input wire logic step_i,
   // state
   output logic done_o
);

   logic [W-1:0] cnt_ff;
   logic done_ff;
   logic [W-1:0] nxt_cnt;

   // counts down on each step, never below zero
   assign nxt_cnt = (step_i && cnt_ff != '0) ? cnt_ff - 1'b1 : cnt_ff;

   // hold keeps the preset loaded and done low
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i || hold_i) begin
         cnt_ff <= PRESET;
         done_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         done_ff <= (nxt_cnt == '0);
      end
   end

   assign done_o = done_ff;

endmodule : dcru_stable_timer

// *** dcru_top_props.sv ***
// dcru_top_props: port-level checks of the clock and reset unit
// assumes it is bound into dcru_top; one core clock, synchronous low reset
`timescale 1ns/1ps
module dcru_top_props #(
   parameter logic [13:0] MAIN_PRESET = 14'h3fff
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rstn_i,
   // apb
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // requests and pins
   input wire logic stop_main_osc_i,
   input wire logic stop_slow_osc_i,
   input wire logic ext_rst_n_i,
   // watched outputs
   input wire logic main_osc_en_o,
   input wire logic slow_osc_en_o,
   input wire logic main_good_o,
   input wire logic slow_good_o,
   input wire logic sys_rst_n_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   localparam int GOOD_CYC = 2 * MAIN_PRESET;
   logic [15:0] run_cnt_ff;
   logic [15:0] nxt_run_cnt;
   // cycles since the main halt dropped; saturates so a long run never wraps
   assign nxt_run_cnt = stop_main_osc_i ? 16'h0000 :
                        (run_cnt_ff == 16'hffff) ? run_cnt_ff : run_cnt_ff + 16'h0001;
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) run_cnt_ff <= 16'h0000;
      else run_cnt_ff <= nxt_run_cnt;
   end
   sequence s_wait_access;
      psel_i && penable_i && !pready_o;
   endsequence
   sequence s_pin_low;
      !ext_rst_n_i [*4];
   endsequence
   property p_main_halt;
      stop_main_osc_i |=> !main_osc_en_o && !main_good_o;
   endproperty
   a_main_halt: assert property (p_main_halt) else $error("main halt ignored");
   property p_slow_halt;
      stop_slow_osc_i |=> !slow_osc_en_o && !slow_good_o;
   endproperty
   a_slow_halt: assert property (p_slow_halt) else $error("slow halt ignored");
   property p_main_restart;
      $fell(stop_main_osc_i) |=> main_osc_en_o;
   endproperty
   a_main_restart: assert property (p_main_restart) else $error("main not restarted");
   property p_main_early;
      $rose(main_good_o) |-> run_cnt_ff >= 16'(GOOD_CYC - 1);
   endproperty
   a_main_early: assert property (p_main_early) else $error("main good too early");
   property p_main_late;
      run_cnt_ff == 16'(GOOD_CYC + 6) |-> main_good_o;
   endproperty
   a_main_late: assert property (p_main_late) else $error("main good too late");
   property p_slow_wait;
      $fell(stop_slow_osc_i) |-> !slow_good_o [*8];
   endproperty
   a_slow_wait: assert property (p_slow_wait) else $error("slow good skipped count");
   property p_ready;
      s_wait_access |=> pready_o;
   endproperty
   a_ready: assert property (p_ready) else $error("apb answer missing");
   property p_ready_pulse;
      pready_o |=> !pready_o;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
   property p_err;
      pslverr_o |-> pready_o;
   endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_ext_rst;
      s_pin_low |-> !sys_rst_n_o;
   endproperty
   a_ext_rst: assert property (p_ext_rst) else $error("pin reset not applied");
endmodule : dcru_top_props

bind dcru_top dcru_top_props #(.MAIN_PRESET(MAIN_PRESET)) u_props (
   .core_clk_i(core_clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
   .pready_o(pready_o), .pslverr_o(pslverr_o), .stop_main_osc_i(stop_main_osc_i),
   .stop_slow_osc_i(stop_slow_osc_i), .ext_rst_n_i(ext_rst_n_i),
   .main_osc_en_o(main_osc_en_o), .slow_osc_en_o(slow_osc_en_o),
   .main_good_o(main_good_o), .slow_good_o(slow_good_o), .sys_rst_n_o(sys_rst_n_o)
);

// *** dcru_pmu_model.sv ***
// dcru_pmu_model: power manager and slow crystal beside the unit
// assumes bench commands change just after a rising core clock edge
`timescale 1ns/1ps
module dcru_pmu_model #(
   parameter int HALF_CYC = 153
) (
   // clock
   input wire logic core_clk_i,
   // bench commands
   input wire logic halt_main_i,
   input wire logic halt_slow_i,
   input wire logic osc_run_i,
   // unit side
   input wire logic slow_osc_en_i,
   output logic stop_main_osc_o,
   output logic stop_slow_osc_o,
   output logic slow_osc_o
);
   int cnt = 0;
   initial begin
      stop_main_osc_o = 1'b0;
      stop_slow_osc_o = 1'b0;
      slow_osc_o = 1'b0;
   end
   // halt requests are levels, held for as long as the bench asks
   always @(posedge core_clk_i) begin
      stop_main_osc_o <= halt_main_i;
      stop_slow_osc_o <= halt_slow_i;
   end
   // a disabled crystal freezes at its last level, so it only swings when enabled
   always @(posedge core_clk_i) begin
      if (osc_run_i && slow_osc_en_i) begin
         cnt <= (cnt == HALF_CYC - 1) ? 0 : cnt + 1;
         if (cnt == HALF_CYC - 1) slow_osc_o <= ~slow_osc_o;
      end
   end
endmodule : dcru_pmu_model

// *** dual_clock_reset_unit_tb_top.sv ***
// dual_clock_reset_unit_tb_top: self-checking bench with a register model
// assumes a short main start-up preset so the run stays brief
`timescale 1ns/1ps
module dual_clock_reset_unit_tb_top;
   localparam logic [13:0] PRESET = 14'h0010;
   logic core_clk_i = 1'b0, rstn_i = 1'b0, ext_rst_n_i = 1'b1;
   logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
   logic pready_o, pslverr_o, err, stop_main_osc_i, stop_slow_osc_i, slow_osc_i;
   logic main_osc_en_o, slow_osc_en_o, main_good_o, slow_good_o, slow_clk_o;
   logic aux_first_en_o, aux_second_en_o, sys_rst_n_o, irq_o;
   logic halt_main = 1'b0, halt_slow = 1'b0, osc_run = 1'b0;
   int failures = 0, checks_done = 0, seed = 99, n, k, sd, d;
   int mdl [3];
   wire [2:0] taps = {aux_second_en_o, aux_first_en_o, slow_clk_o};
   wire [2:0] flg = {slow_good_o, main_good_o, sys_rst_n_o};

   // clock, 100 ns period
   always #50 core_clk_i = ~core_clk_i;

   dcru_top #(.MAIN_PRESET(PRESET)) dut (
      .core_clk_i(core_clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .stop_main_osc_i(stop_main_osc_i),
      .stop_slow_osc_i(stop_slow_osc_i), .ext_rst_n_i(ext_rst_n_i), .slow_osc_i(slow_osc_i),
      .main_osc_en_o(main_osc_en_o), .slow_osc_en_o(slow_osc_en_o),
      .main_good_o(main_good_o), .slow_good_o(slow_good_o), .slow_clk_o(slow_clk_o),
      .aux_first_en_o(aux_first_en_o), .aux_second_en_o(aux_second_en_o),
      .sys_rst_n_o(sys_rst_n_o), .irq_o(irq_o));

   dcru_pmu_model u_pmu (
      .core_clk_i(core_clk_i), .halt_main_i(halt_main), .halt_slow_i(halt_slow),
      .osc_run_i(osc_run), .slow_osc_en_i(slow_osc_en_o), .stop_main_osc_o(stop_main_osc_i),
      .stop_slow_osc_o(stop_slow_osc_i), .slow_osc_o(slow_osc_i));

   task automatic conclude();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one apb transfer; the request is held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
      int j;
      @(posedge core_clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= v;
      @(posedge core_clk_i);
      penable_i <= 1'b1;
      j = 0;
      do begin
         @(negedge core_clk_i);
         j++;
      end while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      chk(j, 2);
      @(posedge core_clk_i);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb

   // write through the bus and into the model; the power-up flag only ever clears
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      apb(1'b1, a, v);
      if (a == 8'h00) mdl[0] = (v & 1) | (mdl[0] & v & 2);
      else if (a < 8'h0c) mdl[a >> 2] = v & 32'hff;
   endtask : wr

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rchk

   // cycles between two rising edges of a derived clock or pulse
   task automatic period(input int s, output int p);
      int j, r0;
      logic q;
      q = 1'b1;
      r0 = -1;
      p = 0;
      for (j = 0; j < 1500 && p == 0; j++) begin
         @(negedge core_clk_i);
         if (taps[s] && !q) begin
            if (r0 >= 0) p = j - r0;
            r0 = j;
         end
         q = taps[s];
      end
   endtask : period

   task automatic wait_hi(input int s, input int lim, output int c);
      c = 0;
      while (flg[s] !== 1'b1 && c < lim) begin
         @(negedge core_clk_i);
         c++;
      end
   endtask : wait_hi

   task automatic por();
      rstn_i <= 1'b0;
      repeat (16) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      mdl = '{2, 32'hff, 0};
      wait_hi(0, 300, k);
   endtask : por

   // watchdog against a hang
   initial begin
      #(100 * 60000);
      failures++;
      conclude();
   end

   initial begin
      por();
      chk(k >= 2 * PRESET && k <= 2 * PRESET + 8, 1);
      rchk(8'h00, mdl[0]);
      rchk(8'h04, mdl[1]);
      rchk(8'h08, mdl[2]);
      apb(1'b0, 8'h18, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      period(0, n);
      chk(n, 512);
      wr(8'h00, 32'hfe);
      rchk(8'h00, mdl[0]);
      wr(8'h00, 32'h0);
      rchk(8'h00, mdl[0]);
      sd = 49 + $unsigned($random(seed)) % 8;
      wr(8'h04, sd);
      rchk(8'h04, mdl[1]);
      period(0, n);
      chk(n, 2 * (sd + 1));
      d = ($random(seed) & 32'hee) | 32'h11;
      wr(8'h08, d);
      period(1, n);
      chk(n, (d & 15) + 1);
      period(2, n);
      chk(n, (d >> 4) + 1);
      wr(8'h0c, 32'h7);
      halt_main <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      chk({main_osc_en_o, main_good_o}, 0);
      halt_main <= 1'b0;
      wait_hi(1, 200, k);
      chk(k >= 2 * PRESET && k <= 2 * PRESET + 5, 1);
      rchk(8'h0c, 32'h1);
      chk(irq_o, 1'b0);
      wr(8'h10, 32'h1);
      repeat (2) @(posedge core_clk_i);
      chk(irq_o, 1'b1);
      wr(8'h0c, 32'h1);
      repeat (2) @(posedge core_clk_i);
      chk(irq_o, 1'b0);
      wr(8'h00, 32'h1);
      rchk(8'h0c, 32'h4);
      period(0, n);
      chk(n, 2 * (sd + 1));
      osc_run <= 1'b1;
      wait_hi(2, 30000, k);
      chk(slow_good_o, 1'b1);
      repeat (700) @(posedge core_clk_i);
      rchk(8'h14, 32'h1f);
      period(0, n);
      chk(n >= 300 && n <= 312, 1);
      halt_slow <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      chk({slow_osc_en_o, slow_good_o}, 0);
      repeat (700) @(posedge core_clk_i);
      period(0, n);
      chk(n, 2 * (sd + 1));
      halt_slow <= 1'b0;
      ext_rst_n_i <= 1'b0;
      repeat (10) @(posedge core_clk_i);
      chk(sys_rst_n_o, 1'b0);
      ext_rst_n_i <= 1'b1;
      wait_hi(0, 50, k);
      mdl = '{0, 32'hff, 0};
      rchk(8'h00, mdl[0]);
      rchk(8'h04, mdl[1]);
      rchk(8'h08, mdl[2]);
      por();
      rchk(8'h00, mdl[0]);
      conclude();
   end
endmodule : dual_clock_reset_unit_tb_top
